// File: design/cop_option_regs.svh
/*
  Offsets, field positions and reset values of the two configuration option
  bytes, plus the address bounds of the guarded flash areas.
  Assumes a 12-bit program address space for the on-chip flash.
*/
`ifndef COP_OPTION_REGS_SVH
`define COP_OPTION_REGS_SVH

// option byte locations in program memory
`define COP_REGION_OPT_OFS   12'h01e
`define COP_CORE_OPT_OFS     12'h01f
`define COP_OPT_RESET        8'h00

// core option byte fields
`define COP_CORE_RDLOCK_BIT  3'd7
`define COP_CORE_WRLOCK_BIT  3'd6
`define COP_CORE_VECTOR_BIT  3'd4
`define COP_CORE_RSTSEL_BIT  3'd0

// region option byte fields
`define COP_REGION_EN_BIT    3'd2
`define COP_REGION_SZ_HI     3'd1
`define COP_REGION_SZ_LO     3'd0

// guarded address bounds
`define COP_VECTOR_LAST      12'h0ff
`define COP_REGION_FIRST     12'h100
`define COP_REGION_LAST_0    12'h3ff
`define COP_REGION_LAST_1    12'h7ff
`define COP_REGION_LAST_2    12'hbff
`define COP_REGION_LAST_3    12'hf7f

`endif

// File: design/cop_pkg.sv
/*
  Types shared by the option protection block.
  Assumes the option constants header is compiled alongside.
*/
package cop_pkg;

  // flash operation kinds from the sequencer
  typedef enum logic [0:0] {
    COP_OP_ERASE = 1'b0,
    COP_OP_WRITE = 1'b1
  } cop_op_t;

  // one flash erase or write request
  typedef struct packed {
    logic        valid;
    cop_op_t     op;
    logic [11:0] addr;
  } cop_req_t;

  // decoded protection controls
  typedef struct packed {
    logic       read_lock;
    logic       code_write_lock;
    logic       vector_area_guard;
    logic       reset_pin_select;
    logic       region_guard_enable;
    logic [1:0] region_size;
  } cop_ctrl_t;

endpackage

// File: design/cop_option_guard.sv
/*
  Latches the two configuration option bytes during reset and decodes them
  into flash erase/write guards, an external read lock and the function of
  the shared reset/port pin.
  Assumes the flash array presents the option bytes on its ports while the
  reset is held, and that the sequencer only acts on an accepted request.
*/
// Behaviour
// - core option bit 7 locks reads, bit 6 writes, bit 4 guards vectors, bit 0 picks reset.
// - with the vector guard set, erase of addresses 00 to ff is refused.
// - reset pin select 0 makes the shared pin a port pin, 1 makes it the reset input.
// - region option bit 2 enables the region guard and bits 1:0 give its size.
// - with the region guard enabled, erase and write inside the region are refused.
// - the size code has no effect unless the region guard is enabled.
// - the region starts at 0100 and ends at 03ff, 07ff, 0bff or 0f7f by size code.
`timescale 1ns/1ps
`default_nettype none
`include "cop_option_regs.svh"

module cop_option_guard (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  // option bytes from the flash array
  input  wire logic [7:0]        core_opt_in,
  input  wire logic [7:0]        region_opt_in,
  // flash request from the sequencer
  input  wire cop_pkg::cop_req_t req_in,
  output logic                   req_accept_out,
  output logic                   req_reject_out,
  // external program read
  input  wire logic              ext_rd_req_in,
  output logic                   ext_rd_allow_out,
  // shared pin
  input  wire logic              shared_port_pin_in,
  output logic                   external_reset_pin_n_out,
  output logic                   port_data_out,
  // option readback
  output logic [7:0]             core_protect_option_out,
  output logic [7:0]             region_protect_option_out
);

  cop_pkg::cop_ctrl_t ctrl_q;
  cop_pkg::cop_ctrl_t ctrl_d;
  logic               rst_n_q;
  logic               rst_n_d;
  logic               port_q;
  logic               port_d;
  logic [11:0]        region_last;
  logic               in_vector;
  logic               in_region;
  logic               blocked;

  // capture during reset
  // next options: held in reset, loaded from the array; fixed afterwards
  always_comb begin
    ctrl_d = ctrl_q;
    if (!nrst_in) begin
      ctrl_d.read_lock         = core_opt_in[`COP_CORE_RDLOCK_BIT];
      ctrl_d.code_write_lock   = core_opt_in[`COP_CORE_WRLOCK_BIT];
      ctrl_d.vector_area_guard = core_opt_in[`COP_CORE_VECTOR_BIT];
      ctrl_d.reset_pin_select  = core_opt_in[`COP_CORE_RSTSEL_BIT];
      ctrl_d.region_guard_enable = region_opt_in[`COP_REGION_EN_BIT];
      ctrl_d.region_size         = region_opt_in[`COP_REGION_SZ_HI:`COP_REGION_SZ_LO];
    end
  end

  always_ff @(posedge mclk_in) begin
    ctrl_q <= ctrl_d;
  end

  always_comb begin
    case (ctrl_q.region_size)
      2'h0:    region_last = `COP_REGION_LAST_0;
      2'h1:    region_last = `COP_REGION_LAST_1;
      2'h2:    region_last = `COP_REGION_LAST_2;
      2'h3:    region_last = `COP_REGION_LAST_3;
      default: region_last = `COP_REGION_LAST_0;
    endcase
  end

  assign in_region = ctrl_q.region_guard_enable && (req_in.addr >= `COP_REGION_FIRST)
                     && (req_in.addr <= region_last);
  assign in_vector = req_in.addr <= `COP_VECTOR_LAST;

  // refusal decode; combinational so the sequencer sees it in the request cycle
  always_comb begin
    blocked = 1'b0;
    if (ctrl_q.vector_area_guard && in_vector && req_in.op == cop_pkg::COP_OP_ERASE) begin
      blocked = 1'b1;
    end
    if (in_region) begin
      blocked = 1'b1;
    end
    if (ctrl_q.code_write_lock && req_in.op == cop_pkg::COP_OP_WRITE) begin
      blocked = 1'b1;
    end
  end

  // refused request never reaches the array
  assign req_accept_out = nrst_in && req_in.valid && !blocked;
  assign req_reject_out = nrst_in && req_in.valid && blocked;

  assign ext_rd_allow_out = nrst_in && ext_rd_req_in && !ctrl_q.read_lock;

  // shared pin routing
  // registered so the reset and port paths never glitch on decode changes
  always_comb begin
    rst_n_d = 1'b1;
    port_d  = 1'b0;
    if (nrst_in) begin
      if (ctrl_q.reset_pin_select) begin
        rst_n_d = shared_port_pin_in;
      end else begin
        port_d = shared_port_pin_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    rst_n_q <= rst_n_d;
    port_q  <= port_d;
  end

  assign external_reset_pin_n_out = rst_n_q;
  assign port_data_out            = port_q;

  // readback with reserved bits as zero
  assign core_protect_option_out = {ctrl_q.read_lock, ctrl_q.code_write_lock, 1'b0,
                                    ctrl_q.vector_area_guard, 3'h0, ctrl_q.reset_pin_select};
  assign region_protect_option_out = {5'h00, ctrl_q.region_guard_enable, ctrl_q.region_size};

  // checks
  vector_erase_guard_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.vector_area_guard && req_in.addr <= 12'h0ff
     && req_in.op == cop_pkg::COP_OP_ERASE) |-> (req_reject_out && !req_accept_out))
    else $error("vector erase not refused");
  vector_open_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && req_in.addr <= 12'h0ff && !ctrl_q.code_write_lock
     && (!ctrl_q.vector_area_guard || req_in.op == cop_pkg::COP_OP_WRITE))
    |-> req_accept_out)
    else $error("vector area wrongly refused");
  region_guard_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.region_guard_enable && req_in.addr >= 12'h100
     && req_in.addr <= 12'h3ff) |-> req_reject_out)
    else $error("region access not refused");
  region_size_top_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.region_guard_enable && ctrl_q.region_size == 2'h3
     && req_in.addr == 12'hf80 && !ctrl_q.code_write_lock) |-> req_accept_out)
    else $error("region end overshoots");
  region_off_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && !ctrl_q.region_guard_enable && req_in.addr >= 12'h100
     && !ctrl_q.code_write_lock) |-> req_accept_out)
    else $error("size code acted while disabled");
  write_lock_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.code_write_lock && req_in.op == cop_pkg::COP_OP_WRITE)
    |-> !req_accept_out)
    else $error("write passed the lock");
  read_lock_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ext_rd_req_in |-> (ext_rd_allow_out == !core_protect_option_out[7]))
    else $error("read lock mismatch");
  options_stable_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $past(nrst_in) |-> $stable(core_protect_option_out) && $stable(region_protect_option_out))
    else $error("options changed outside reset");
  pin_route_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (nrst_in && !core_protect_option_out[0]) ##1 $stable(core_protect_option_out)
    |-> (external_reset_pin_n_out && port_data_out == $past(shared_port_pin_in)))
    else $error("pin not routed as port");
  option_load_a: assert property (@(posedge mclk_in)
    (!nrst_in ##1 nrst_in) |-> (core_protect_option_out == ($past(core_opt_in) & 8'hd1)))
    else $error("core option not latched");

  region_load_a: assert property (@(posedge mclk_in)
    (!nrst_in ##1 nrst_in) |-> (region_protect_option_out == ($past(region_opt_in) & 8'h07)))
    else $error("region option not latched");

  reset_quiet_a: assert property (@(posedge mclk_in)
    !nrst_in |-> (!req_accept_out && !req_reject_out && !ext_rd_allow_out))
    else $error("output active during reset");

  blank_options_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && core_protect_option_out == 8'h00
     && region_protect_option_out == 8'h00) |-> req_accept_out)
    else $error("blank options refused a request");

  region_one_last_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.region_guard_enable && ctrl_q.region_size == 2'h1
     && req_in.addr == 12'h7ff) |-> req_reject_out)
    else $error("region end too low for code 1");

  region_mid_last_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.region_guard_enable && ctrl_q.region_size == 2'h2
     && req_in.addr == 12'hbff) |-> req_reject_out)
    else $error("region end too low for code 2");

  region_mid_next_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (req_in.valid && ctrl_q.region_guard_enable && ctrl_q.region_size == 2'h2
     && req_in.addr == 12'hc00 && !ctrl_q.code_write_lock) |-> req_accept_out)
    else $error("region end too high for code 2");

  pin_reset_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (nrst_in && core_protect_option_out[0]) ##1 $stable(core_protect_option_out)
    |-> (!port_data_out && external_reset_pin_n_out == $past(shared_port_pin_in)))
    else $error("pin not routed as reset");

endmodule

`default_nettype wire

// File: verification/cop_flash_model.sv
/*
  Behavioural flash array side: keeps the two option bytes stored by the
  programming tool and presents them to the guard.
  Assumes the bench plays the tool and strobes one byte at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module cop_flash_model (
  // programming tool port
  input  wire logic        prog_en_in,
  input  wire logic [11:0] prog_addr_in,
  input  wire logic [7:0]  prog_data_in,
  // option bytes toward the guard
  output logic [7:0]       core_opt_out,
  output logic [7:0]       region_opt_out
);
  logic [7:0] core_q   = 8'h00;
  logic [7:0] region_q = 8'h00;

  // tool stores options
  // other addresses are ignored, the model only holds the option area
  always @(posedge prog_en_in) begin
    if (prog_addr_in == 12'h01f) core_q <= prog_data_in;
    if (prog_addr_in == 12'h01e) region_q <= prog_data_in;
  end

  assign core_opt_out   = core_q;
  assign region_opt_out = region_q;
endmodule
`default_nettype wire

// File: verification/config_option_protection_test.sv
/*
  Self-checking bench for the option guard: programs option bytes, resets,
  then checks readback, request guards, read lock and pin function.
  Assumes the guard latches options only while reset is low.
*/
`timescale 1ns/1ps
`default_nettype none

module config_option_protection_test;
  logic              mclk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic              prog_en = 1'b0;
  logic [11:0]       prog_addr = 12'h000;
  logic [7:0]        prog_data = 8'h00;
  logic [7:0]        core_opt, region_opt, core_rb, region_rb;
  cop_pkg::cop_req_t req = '0;
  logic              ext_rd = 1'b0;
  logic              pin = 1'b0;
  logic              accept, reject, rd_allow, rst_n, port_d;
  int                error_cnt = 0;
  int                compares = 0;
  logic [11:0] addrs [12] = '{12'h000, 12'h0ff, 12'h100, 12'h3ff, 12'h400, 12'h7ff,
                              12'h800, 12'hbff, 12'hc00, 12'hf7f, 12'hf80, 12'hfff};
  logic [11:0] ends [4] = '{12'h3ff, 12'h7ff, 12'hbff, 12'hf7f};
  logic [7:0]  cores [6] = '{8'h00, 8'hd1, 8'h40, 8'h80, 8'h10, 8'h01};
  logic [7:0]  regions [6] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h03};

  // 20 MHz clock
  always #25 mclk_in = ~mclk_in;

  cop_flash_model u_cop_flash_model (.prog_en_in(prog_en), .prog_addr_in(prog_addr),
    .prog_data_in(prog_data), .core_opt_out(core_opt), .region_opt_out(region_opt));

  cop_option_guard u_cop_option_guard (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .core_opt_in(core_opt), .region_opt_in(region_opt), .req_in(req),
    .req_accept_out(accept), .req_reject_out(reject), .ext_rd_req_in(ext_rd),
    .ext_rd_allow_out(rd_allow), .shared_port_pin_in(pin),
    .external_reset_pin_n_out(rst_n), .port_data_out(port_d),
    .core_protect_option_out(core_rb), .region_protect_option_out(region_rb));

  // compare tasks, one per result width
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %b got %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  // strobe one byte into the array as the tool would
  task automatic program_byte(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    prog_addr = a;
    prog_data = d;
    prog_en = 1'b1;
    @(negedge mclk_in);
    prog_en = 1'b0;
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one option set: program, reset, then sweep every guarded boundary
  task automatic run_case(input int i);
    logic [7:0]  c;
    logic [7:0]  r;
    logic [11:0] a;
    logic        rej;
    c = cores[i];
    r = regions[i];
    program_byte(12'h01f, c);
    program_byte(12'h01e, r);
    @(negedge mclk_in);
    nrst_in = 1'b0;
    // a request and a read held across reset must see no answer
    req.valid = 1'b1;
    ext_rd = 1'b1;
    repeat (2) @(negedge mclk_in);
    chk_bit("reset quiet", 1'b0, accept | reject | rd_allow);
    chk_bit("reset pins", 1'b1, rst_n & !port_d);
    nrst_in = 1'b1;
    req.valid = 1'b0;
    ext_rd = 1'b0;
    // changed array contents after reset must not leak into the guards
    program_byte(12'h01f, ~c);
    program_byte(12'h01e, ~r);
    chk_byte("core readback", c & 8'hd1, core_rb);
    chk_byte("region readback", r & 8'h07, region_rb);
    for (int k = 0; k < 24; k++) begin
      a = addrs[k / 2];
      req.valid = 1'b1;
      req.op = cop_pkg::cop_op_t'(k[0]);
      req.addr = a;
      rej = (!k[0] && c[4] && a <= 12'h0ff) || (k[0] && c[6]) ||
            (r[2] && a >= 12'h100 && a <= ends[r[1:0]]);
      #1;
      chk_bit("reject", rej, reject);
      chk_bit("accept", !rej, accept);
      @(negedge mclk_in);
    end
    req.valid = 1'b0;
    ext_rd = 1'b1;
    #1;
    chk_bit("idle accept", 1'b0, accept);
    chk_bit("idle reject", 1'b0, reject);
    chk_bit("read allow", !c[7], rd_allow);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk_in);
      ext_rd = 1'b0;
      pin = k[0];
      @(negedge mclk_in);
      chk_bit("pin reset_n", c[0] ? k[0] : 1'b1, rst_n);
      chk_bit("pin port", c[0] ? 1'b0 : k[0], port_d);
    end
    $display("case %0d done", i);
  endtask

  // main sequence
  initial begin
    repeat (6) @(negedge mclk_in);
    nrst_in = 1'b1;
    for (int i = 0; i < 6; i++) run_case(i);
    print_verdict();
  end

  // watchdog well beyond the few hundred cycles the cases need
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
